/* File: tlb_inv_pkg.sv */
// Package of register map, field layout and types for the translation-cache invalidation block
`default_nettype none
package tlb_inv_pkg;
   // Byte addresses of 32-bit APB words
   localparam logic [11:0] ADDR_REG_OFFSET = 12'h100;
   localparam logic [11:0] CMD_REG_OFFSET = ADDR_REG_OFFSET + 12'h008;
   localparam logic [11:0] ADDR_LO = ADDR_REG_OFFSET;
   localparam logic [11:0] ADDR_HI = ADDR_REG_OFFSET + 12'h004;
   localparam logic [11:0] CMD_LO = CMD_REG_OFFSET;
   localparam logic [11:0] CMD_HI = CMD_REG_OFFSET + 12'h004;
   localparam logic [11:0] EXT_CAP_LO = 12'h010;
   localparam logic [11:0] CAP_LO = 12'h008;
   localparam logic [11:0] IRQ_STATUS = 12'h200;
   localparam logic [11:0] IRQ_MASK = 12'h204;
   localparam logic [11:0] CTRL = 12'h208;
   // Field positions in the command words and the capability and extended capability words
   localparam int GO_BIT = 31;
   localparam int REQ_GRAN_LSB = 28;
   localparam int ACT_GRAN_LSB = 25;
   localparam int DID_LSB = 0;
   localparam int DID_WIDTH = 16;
   localparam int OFFSET_LSB = 8;
   localparam int WRITE_BUFFER_FLUSH_REQUIRED_BIT = 4;
   // Reset values
   localparam logic [31:0] CMD_HI_RESET = 32'h0000_0000;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // Timing in cycles
   localparam int FLUSH_CYCLES = 4;
   localparam int INV_CYCLES = 8;
   typedef enum logic [1:0] {
      gran_rsvd = 2'b00,
      gran_global = 2'b01,
      gran_domain = 2'b10,
      gran_page = 2'b11
   } gran_t;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_flush = 2'b01,
      st_inv = 2'b10
   } inv_state_t;
   typedef struct packed {
      logic go;
      gran_t gran;
      logic [15:0] domain;
      logic [63:0] target;
   } inv_req_t;
endpackage : tlb_inv_pkg
`default_nettype wire

/* File: tlb_inv_timer.sv */
// Down counter that times one flush or invalidation phase
`default_nettype none
module tlb_inv_timer
   import tlb_inv_pkg::*;
#(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   output logic done
);
   logic [WIDTH-1:0] remain;
   logic running;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remain <= '0;
         running <= 1'b0;
      end else if (load) begin
         remain <= count;
         running <= 1'b1;
      end else if (running) begin
         remain <= remain - 1'b1;
         running <= (remain != 1);
      end
   end
   assign done = running && (remain == 1);
endmodule : tlb_inv_timer
`default_nettype wire

/* File: tlb_inv_regs.sv */
// APB slave address decode and write strobes for the invalidation block
`default_nettype none
module tlb_inv_regs
   import tlb_inv_pkg::*;
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Decoded strobes
   output logic wr_addr_lo,
   output logic wr_addr_hi,
   output logic wr_cmd_lo,
   output logic wr_cmd_hi,
   output logic wr_status,
   output logic wr_mask,
   output logic wr_ctrl,
   output logic hit
);
   wire access = psel && penable;
   wire wr = access && pwrite;
   assign hit = (paddr == ADDR_LO) || (paddr == ADDR_HI) || (paddr == CMD_LO) || (paddr == CMD_HI) ||
                (paddr == CAP_LO) || (paddr == EXT_CAP_LO) || (paddr == IRQ_STATUS) ||
                (paddr == IRQ_MASK) || (paddr == CTRL);
   assign wr_addr_lo = wr && (paddr == ADDR_LO);
   assign wr_addr_hi = wr && (paddr == ADDR_HI);
   assign wr_cmd_lo = wr && (paddr == CMD_LO);
   assign wr_cmd_hi = wr && (paddr == CMD_HI);
   assign wr_status = wr && (paddr == IRQ_STATUS);
   assign wr_mask = wr && (paddr == IRQ_MASK);
   assign wr_ctrl = wr && (paddr == CTRL);
endmodule : tlb_inv_regs
`default_nettype wire

/* File: tlb_inv.sv */
// Translation-cache invalidation command block with APB registers
//
// Implementation choices: the address map and the APB interface to the registers.
`default_nettype none
module tlb_inv
   import tlb_inv_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Cache side
   output logic flush_req,
   output logic inv_req,
   output inv_req_t inv_info,
   // Interrupt
   output logic irq
);
   logic wr_addr_lo, wr_addr_hi, wr_cmd_lo, wr_cmd_hi, wr_status, wr_mask, wr_ctrl, hit;
   logic [63:0] target;
   logic [31:0] cmd_lo;
   logic go;
   gran_t req_gran, act_gran;
   logic write_buffer_flush_required;
   logic [1:0] status, mask;
   inv_state_t state, next_state;
   logic timer_load, timer_done;
   logic [3:0] timer_count;
   tlb_inv_regs u_regs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .wr_addr_lo(wr_addr_lo), .wr_addr_hi(wr_addr_hi),
      .wr_cmd_lo(wr_cmd_lo), .wr_cmd_hi(wr_cmd_hi), .wr_status(wr_status), .wr_mask(wr_mask),
      .wr_ctrl(wr_ctrl), .hit(hit)
   );
   tlb_inv_timer #(.WIDTH(4)) u_timer (
      .pclk(pclk), .presetn(presetn), .load(timer_load), .count(timer_count), .done(timer_done)
   );
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   // Start only on an upper-word write with go set while idle
   wire start = wr_cmd_hi && pwdata[GO_BIT] && !go;
   wire flush_done = (state == st_flush) && timer_done;
   wire inv_done = (state == st_inv) && timer_done;
   // Page requests are served exactly; reserved requests widen to global
   gran_t served;
   assign served = (req_gran == gran_rsvd) ? gran_global : req_gran;
   always_comb begin
      next_state = state;
      timer_load = 1'b0;
      timer_count = 4'(INV_CYCLES);
      case (state)
         st_idle: begin
            if (start) begin
               timer_load = 1'b1;
               if (write_buffer_flush_required) begin
                  next_state = st_flush;
                  timer_count = 4'(FLUSH_CYCLES);
               end else begin
                  next_state = st_inv;
               end
            end
         end
         st_flush: begin
            if (flush_done) begin
               next_state = st_inv;
               timer_load = 1'b1;
            end
         end
         st_inv: begin
            if (inv_done) begin
               next_state = st_idle;
            end
         end
         default: next_state = st_idle;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_idle;
      end else begin
         state <= next_state;
      end
   end
   // Address and low command registers frozen while busy by gating their writes with go
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target <= '0;
         cmd_lo <= '0;
      end else begin
         if (wr_addr_lo && !go) target[31:0] <= pwdata;
         if (wr_addr_hi && !go) target[63:32] <= pwdata;
         if (wr_cmd_lo && !go) cmd_lo <= pwdata;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go <= CMD_HI_RESET[GO_BIT];
         req_gran <= gran_rsvd;
         act_gran <= gran_rsvd;
      end else begin
         if (wr_cmd_hi && !go) begin
            req_gran <= gran_t'(pwdata[REQ_GRAN_LSB +: 2]);
         end
         if (start) begin
            go <= 1'b1;
         end else if (inv_done) begin
            go <= 1'b0;
            act_gran <= served;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_buffer_flush_required <= 1'b0;
         mask <= IRQ_MASK_RESET;
         status <= '0;
      end else begin
         if (wr_ctrl) write_buffer_flush_required <= pwdata[0];
         if (wr_mask) mask <= pwdata[1:0];
         // Set wins over write-one-to-clear
         status[0] <= inv_done | (status[0] & ~(wr_status & pwdata[0]));
         // Flag the granularity being written now, not the stored one
         status[1] <= (start & (pwdata[REQ_GRAN_LSB +: 2] == 2'b00)) | (status[1] & ~(wr_status & pwdata[1]));
      end
   end
   assign irq = |(status & mask);
   assign flush_req = (state == st_flush);
   assign inv_req = (state == st_inv);
   assign inv_info = '{go: go, gran: served, domain: cmd_lo[DID_WIDTH-1:0], target: target};
   // Read mux
   wire [31:0] cmd_hi_rd = {go, 1'b0, req_gran, 1'b0, act_gran, 25'h0000000};
   // Offset field holds the address register base in 16-byte units
   wire [7:0] offset_field = ADDR_REG_OFFSET[11:4];
   wire [31:0] ext_cap_rd = {16'h0000, offset_field, 8'h00};
   wire [31:0] cap_rd = {27'h0000000, write_buffer_flush_required, 4'h0};
   assign prdata = (paddr == ADDR_LO) ? target[31:0] :
                   (paddr == ADDR_HI) ? target[63:32] :
                   (paddr == CMD_LO) ? cmd_lo :
                   (paddr == CMD_HI) ? cmd_hi_rd :
                   (paddr == CAP_LO) ? cap_rd :
                   (paddr == EXT_CAP_LO) ? ext_cap_rd :
                   (paddr == IRQ_STATUS) ? {30'h00000000, status} :
                   (paddr == IRQ_MASK) ? {30'h00000000, mask} :
                   (paddr == CTRL) ? {31'h00000000, write_buffer_flush_required} : 32'h00000000;
   // Checks
   chk_go_clears: assert property (@(posedge pclk) disable iff (!presetn)
      inv_done |=> !go) else $error("go not cleared at completion");
   chk_start_sets: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> go) else $error("go not set by start");
   chk_flush_first: assert property (@(posedge pclk) disable iff (!presetn)
      (start && write_buffer_flush_required) |=> flush_req [*4] ##1 inv_req) else $error("flush not before invalidate");
   chk_no_flush: assert property (@(posedge pclk) disable iff (!presetn)
      (start && !write_buffer_flush_required) |=> inv_req [*8] ##1 !go) else $error("invalidate length wrong");
   chk_act_gran: assert property (@(posedge pclk) disable iff (!presetn)
      inv_done |=> act_gran == $past(served)) else $error("actual granularity wrong");
   chk_coarse_ok: assert property (@(posedge pclk) disable iff (!presetn)
      inv_done |=> act_gran != gran_rsvd) else $error("reserved granularity reported");
   chk_no_start: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cmd_lo && !go) |=> !go) else $error("low write started request");
   chk_addr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      go |=> $stable(target) || !$past(go)) else $error("address changed while busy");
   chk_req_gran: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> req_gran == gran_t'($past(pwdata[29:28]))) else $error("granularity not taken");
   cov_global: cover property (@(posedge pclk) disable iff (!presetn) inv_done && served == gran_global);
   cov_page: cover property (@(posedge pclk) disable iff (!presetn) inv_done && served == gran_page);
   cov_flush: cover property (@(posedge pclk) disable iff (!presetn) flush_done);
endmodule : tlb_inv
`default_nettype wire

/* File: test_tlb_inv.sv */
// Self-checking testbench for the translation-cache invalidation block
`default_nettype none
module test_tlb_inv
   import tlb_inv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, flush_req, inv_req, irq;
   inv_req_t inv_info;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n_flush = 0;
   int n_inv = 0;
   int flush_at_inv = -1;
   logic [31:0] seed = 32'h0000_0043;
   logic [31:0] rd;
   logic err;
   logic [11:0] base;
   logic [1:0] seen_gran;
   logic [15:0] seen_dom;
   logic [63:0] seen_tgt;

   tlb_inv dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flush_req(flush_req), .inv_req(inv_req), .inv_info(inv_info), .irq(irq));

   always #12.5 pclk = ~pclk;

   // Cache-side monitor and hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (flush_req === 1'b1) n_flush <= n_flush + 1;
      if (inv_req === 1'b1) begin
         n_inv <= n_inv + 1;
         if (n_inv == 0) flush_at_inv <= n_flush;
         seen_gran <= inv_info.gran;
         seen_dom <= inv_info.domain;
         seen_tgt <= inv_info.target;
      end
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         close_out();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // Reserved request is served as global
   function automatic logic [1:0] exp_act(input logic [1:0] g);
      return (g == 2'h0) ? 2'h1 : g;
   endfunction : exp_act

   function automatic int exp_flush(input logic r);
      return r ? FLUSH_CYCLES : 0;
   endfunction : exp_flush

   task automatic close_out();
      if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic run_inv(input logic [1:0] g, input logic write_buffer_flush_required);
      logic [31:0] dom, tlo, thi, m;
      int k;
      dom = xs() & 32'h0000_FFFF;
      tlo = xs();
      thi = xs();
      m = xs() & 32'h0000_0003;
      apb(1'b1, IRQ_MASK, m);
      apb(1'b1, CTRL, {31'h0, write_buffer_flush_required});
      apb(1'b0, CAP_LO, 32'h0);
      chk("flush capability", {31'h0, write_buffer_flush_required}, {31'h0, rd[WRITE_BUFFER_FLUSH_REQUIRED_BIT]});
      apb(1'b1, base, tlo);
      apb(1'b1, base + 12'h004, thi);
      apb(1'b1, base + 12'h008, dom);
      n_flush = 0;
      n_inv = 0;
      flush_at_inv = -1;
      apb(1'b1, base + 12'h00C, {2'h2, g, 28'h0});
      apb(1'b0, base + 12'h00C, 32'h0);
      chk("go while busy", 32'h1, {31'h0, rd[GO_BIT]});
      // Writes during the operation must be ignored; the shorter run has room for one only
      apb(1'b1, base, ~tlo);
      if (write_buffer_flush_required) apb(1'b1, base + 12'h00C, {2'h2, ~g, 28'h0});
      k = 0;
      do begin
         apb(1'b0, base + 12'h00C, 32'h0);
         k++;
      end while (rd[GO_BIT] !== 1'b0 && k < 40);
      chk("go cleared", 32'h0, {31'h0, rd[GO_BIT]});
      chk("actual gran", {30'h0, exp_act(g)}, {30'h0, rd[ACT_GRAN_LSB +: 2]});
      chk("requested gran", {30'h0, g}, {30'h0, rd[REQ_GRAN_LSB +: 2]});
      chk("flush before inv", exp_flush(write_buffer_flush_required), flush_at_inv);
      chk("inv cycles", INV_CYCLES, n_inv);
      chk("served gran", {30'h0, exp_act(g)}, {30'h0, seen_gran});
      chk("domain", dom, {16'h0, seen_dom});
      chk("target lo", tlo, seen_tgt[31:0]);
      chk("target hi", thi, seen_tgt[63:32]);
      apb(1'b0, base, 32'h0);
      chk("address kept", tlo, rd);
      apb(1'b0, IRQ_STATUS, 32'h0);
      chk("status", {30'h0, g == 2'h0, 1'b1}, rd);
      chk("irq", {31'h0, |({g == 2'h0, 1'b1} & m[1:0])}, {31'h0, irq});
      apb(1'b1, IRQ_STATUS, 32'h0000_0003);
      apb(1'b0, IRQ_STATUS, 32'h0);
      chk("status cleared", 32'h0, rd);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask : run_inv

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, EXT_CAP_LO, 32'h0);
      base = {rd[OFFSET_LSB +: 8], 4'h0};
      chk("offset field", {20'h0, ADDR_REG_OFFSET}, {20'h0, base});
      apb(1'b0, base + 12'h00C, 32'h0);
      chk("cmd reset", CMD_HI_RESET, rd);
      apb(1'b0, IRQ_MASK, 32'h0);
      chk("mask reset", {30'h0, IRQ_MASK_RESET}, rd);
      // Field update with go clear starts nothing
      n_inv = 0;
      apb(1'b1, base + 12'h00C, {4'h2, 28'h0});
      repeat (3) apb(1'b0, base + 12'h00C, 32'h0);
      chk("no go", 32'h0, {31'h0, rd[GO_BIT]});
      chk("gran stored", 32'h2, {30'h0, rd[REQ_GRAN_LSB +: 2]});
      chk("no start", 32'h0, n_inv);
      // No context-cache request is ever pending here
      for (int i = 0; i < 8; i++) run_inv(i[1:0], i[2]);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      close_out();
   end
endmodule : test_tlb_inv
`default_nettype wire
